//--- hw/pcc_pkg.sv
/*
 * constants shared by both ends of the panel CAN message codec.
 * assumes a 100 MHz reference clock and frames exchanged whole, one per handshake.
 */
`default_nettype none
package pcc_pkg;
	// ==========================================
	// timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned MS_NS = 1000000;
	localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
	// ==========================================
	// frame layout
	localparam int unsigned SW_N = 20;
	localparam int unsigned GRP_N = 20;
	localparam int unsigned ANALOG_N = 4;
	localparam int unsigned XID_N = 8;
	localparam int unsigned SLOT_N = 8;
	localparam int unsigned JOB_N = XID_N + 4;
	localparam int unsigned BYTE_TAG = 0;
	localparam int unsigned BYTE_LED = 1;
	localparam int unsigned BYTE_BACK = 2;
	localparam logic [7:0] FAULT_TAG = 8'h0A;
	localparam logic [7:0] BRIGHT_TAG = 8'h34;
	localparam logic [10:0] STD_ID_MAX = 11'h7FF;
	localparam int unsigned ID_EXT_BIT = 29;
	localparam int unsigned ID_EN_BIT = 30;
	// ==========================================
	// export slot kinds (entry: kind [11:8], value [7:0])
	localparam logic [3:0] KIND_NONE = 4'h0;
	localparam logic [3:0] KIND_SW_LO = 4'h1;
	localparam logic [3:0] KIND_SW_HI = 4'h2;
	localparam logic [3:0] KIND_GRP_LO = 4'h3;
	localparam logic [3:0] KIND_GRP_HI = 4'h4;
	localparam logic [3:0] KIND_CONST = 4'h5;
	localparam logic [3:0] KIND_AN8 = 4'h6;
	localparam logic [3:0] KIND_AN_LO = 4'h7;
	localparam logic [3:0] KIND_AN_HI = 4'h8;
	// ==========================================
	// register map of the panel
	localparam int unsigned WB_AW = 9;
	localparam logic [8:0] ADR_CTRL = 9'h000;
	localparam logic [8:0] ADR_KBPS = 9'h004;
	localparam logic [8:0] ADR_PERIOD = 9'h008;
	localparam logic [8:0] ADR_RXID = 9'h00C;
	localparam logic [8:0] ADR_ADV_PRI = 9'h010;
	localparam logic [8:0] ADR_ADV_SEC = 9'h014;
	localparam logic [8:0] ADR_LEG_PRI = 9'h018;
	localparam logic [8:0] ADR_LEG_SEC = 9'h01C;
	localparam logic [8:0] ADR_BRIGHT = 9'h020;
	localparam logic [8:0] ADR_ALTSW = 9'h024;
	localparam logic [8:0] ADR_STATUS = 9'h028;
	localparam logic [3:0] XID_PAGE = 4'h2;
	localparam logic [0:0] SLOT_PAGE = 1'h1;
	localparam int unsigned CTRL_TERM = 0;
	localparam int unsigned CTRL_LEGACY = 1;
	localparam int unsigned CTRL_ON_CHANGE = 2;
	localparam int unsigned CTRL_PERIODIC = 3;
	localparam int unsigned CTRL_EXPORT = 4;
	localparam int unsigned CTRL_ADV_SEC = 5;
	localparam int unsigned CTRL_HW_V1 = 6;
	localparam int unsigned ALT_EN_BIT = 8;
	localparam logic [9:0] KBPS_MIN = 10'd10;
	localparam logic [9:0] KBPS_MAX = 10'd1000;
	localparam logic [9:0] KBPS_RESET = 10'd500;
	localparam logic [15:0] PERIOD_RESET = 16'h0064;
	localparam logic [31:0] BRIGHT_RESET = 32'h4040_FFFF;
	// ==========================================
	// brightness, fault thresholds and scaling
	localparam logic [4:0] V1_FILL = 5'h1F;
	localparam logic [7:0] FAULT_SET_ABOVE = 8'h01;
	localparam logic [7:0] FAULT_CLR_BELOW = 8'h02;
	localparam logic [8:0] SUPPLY_MUL_X10 = 9'd294;
	localparam int unsigned SHIFT_BYTE = 8;
	localparam int unsigned SHIFT_WORD = 10;
endpackage
`default_nettype wire

//--- hw/pcc_can_if.sv
/*
 * frame-level CAN link between the panel and a power module.
 * assumes an external CAN controller serialises each accepted frame.
 */
`default_nettype none
interface pcc_can_if;
	logic p2m_valid;
	logic p2m_ready;
	logic [28:0] p2m_id;
	logic p2m_ext;
	logic [63:0] p2m_data;
	logic m2p_valid;
	logic m2p_ready;
	logic [28:0] m2p_id;
	logic m2p_ext;
	logic [63:0] m2p_data;
	modport panel(output p2m_valid, p2m_id, p2m_ext, p2m_data, m2p_ready,
		input p2m_ready, m2p_valid, m2p_id, m2p_ext, m2p_data);
	modport power(output m2p_valid, m2p_id, m2p_ext, m2p_data, p2m_ready,
		input m2p_ready, p2m_valid, p2m_id, p2m_ext, p2m_data);
endinterface
`default_nettype wire

//--- hw/pcc_power_end.sv
/*
 * power module end: fault events set at level 2 and up and cleared below it, periodic fault frame,
 * brightness command, decode of panel switch and supply frames.
 * assumes the panel end on the other side of pcc_can_if.
 */
`default_nettype none
module pcc_power_end import pcc_pkg::*; #(
	parameter int unsigned MS_CYC = MS_CYCLES
) (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	pcc_can_if.power can,
	input wire logic [7:0] i_fault_level [SW_N],
	input wire logic [29:0] i_fault_ident,
	input wire logic [15:0] i_interval_ms,
	input wire logic i_bright_req,
	input wire logic [7:0] i_bright_led,
	input wire logic [7:0] i_bright_back,
	input wire logic [29:0] i_panel_ident,
	input wire logic [29:0] i_supply_ident,
	input wire logic [2:0] i_supply_slot,
	input wire logic i_supply_word,
	output logic [SW_N-1:0] o_fault_evt,
	output logic [SW_N-1:0] o_panel_sw,
	output logic [15:0] o_supply_dv,
	output logic o_bright_busy
);
	typedef enum logic [0:0] {P_IDLE, P_SEND} pcc_pstate_t;
	localparam int unsigned TW = $clog2(MS_CYC + 1);

	pcc_pstate_t st_q;
	logic [TW-1:0] tick_q;
	logic [15:0] ms_q;
	logic fault_pend_q, bright_pend_q;
	logic [7:0] b_led_q, b_back_q;
	logic [28:0] fid_q;
	logic fext_q;
	logic [63:0] fdata_q;
	logic [SW_N-1:0] evt_q, sw_q;
	logic [15:0] sup_q;

	// ==========================================
	// fault events and frame timing
	logic [SW_N-1:0] evt_d;
	always_comb begin
		for (int i = 0; i < SW_N; i++) begin
			if (i_fault_level[i] > FAULT_SET_ABOVE) begin
				evt_d[i] = 1'h1;
			end else if (i_fault_level[i] < FAULT_CLR_BELOW) begin
				evt_d[i] = 1'h0;
			end else begin
				evt_d[i] = evt_q[i];
			end
		end
	end

	wire tick = (tick_q == TW'(MS_CYC - 1));
	wire interval_done = tick && ({1'h0, ms_q} + 17'h00001 >= {1'h0, i_interval_ms});
	wire load_bright = (st_q == P_IDLE) && bright_pend_q;
	wire load_fault = (st_q == P_IDLE) && !bright_pend_q && fault_pend_q;
	wire sent = (st_q == P_SEND) && can.m2p_ready;
	// fault bits: byte 7 first, then bytes 6 and 5
	wire [63:0] fault_data = {evt_q[7:0], evt_q[15:8], 4'h0, evt_q[19:16], 32'h0000_0000,
		FAULT_TAG};
	wire [63:0] bright_data = {40'h00_0000_0000, b_back_q, b_led_q, BRIGHT_TAG};

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tick_q <= '0;
			ms_q <= '0;
			evt_q <= '0;
			fault_pend_q <= 1'h0;
			bright_pend_q <= 1'h0;
			b_led_q <= '0;
			b_back_q <= '0;
		end else begin
			tick_q <= tick ? '0 : tick_q + TW'(1);
			ms_q <= interval_done ? '0 : (tick ? ms_q + 16'h0001 : ms_q);
			evt_q <= evt_d;
			fault_pend_q <= interval_done || (fault_pend_q && !load_fault);
			bright_pend_q <= i_bright_req || (bright_pend_q && !load_bright);
			if (i_bright_req) begin
				b_led_q <= i_bright_led;
				b_back_q <= i_bright_back;
			end
		end
	end

	// ==========================================
	// transmit
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_q <= P_IDLE;
			fid_q <= '0;
			fext_q <= 1'h0;
			fdata_q <= '0;
		end else begin
			case (st_q)
				P_IDLE: begin
					if (load_bright || load_fault) begin
						st_q <= P_SEND;
						fext_q <= i_fault_ident[ID_EXT_BIT];
						fid_q <= i_fault_ident[ID_EXT_BIT] ? i_fault_ident[28:0]
							: {18'h00000, i_fault_ident[10:0] & STD_ID_MAX};
						fdata_q <= load_bright ? bright_data : fault_data;
					end
				end
				P_SEND: begin
					if (sent) begin
						st_q <= P_IDLE;
					end
				end
				default: st_q <= P_IDLE;
			endcase
		end
	end

	assign can.m2p_valid = (st_q == P_SEND);
	assign can.m2p_id = fid_q;
	assign can.m2p_ext = fext_q;
	assign can.m2p_data = fdata_q;
	assign can.p2m_ready = 1'h1;

	// ==========================================
	// receive from panel
	function automatic logic id_match(input logic [29:0] r);
		logic [28:0] want;
		want = r[ID_EXT_BIT] ? r[28:0] : {18'h00000, r[10:0]};
		id_match = (can.p2m_ext == r[ID_EXT_BIT]) && (can.p2m_id == want);
	endfunction

	wire [7:0] sup_lo = can.p2m_data[{i_supply_slot, 3'h0} +: 8];
	wire [7:0] sup_hi = can.p2m_data[{i_supply_slot + 3'h1, 3'h0} +: 8];
	// word form arrives low byte first
	wire [15:0] sup_raw = i_supply_word ? {sup_hi, sup_lo} : {8'h00, sup_lo};
	wire [24:0] sup_prod = sup_raw * SUPPLY_MUL_X10;
	// tenths of a volt: x29.4 then /256 or /1024
	wire [24:0] sup_scaled = i_supply_word ? (sup_prod >> SHIFT_WORD)
		: (sup_prod >> SHIFT_BYTE);

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sw_q <= '0;
			sup_q <= '0;
		end else if (can.p2m_valid) begin
			if (id_match(i_panel_ident)) begin
				sw_q <= {can.p2m_data[43:40], can.p2m_data[55:48], can.p2m_data[63:56]};
			end
			if (id_match(i_supply_ident)) begin
				sup_q <= sup_scaled[15:0];
			end
		end
	end

	assign o_fault_evt = evt_q;
	assign o_panel_sw = sw_q;
	assign o_supply_dv = sup_q;
	assign o_bright_busy = bright_pend_q || (st_q == P_SEND);
endmodule
`default_nettype wire

//--- hw/pcc_panel_end.sv
/*
 * membrane panel end: wishbone configuration, legacy fault and brightness
 * reception, advanced, legacy and export frame transmission.
 * assumes an external CAN controller and a keyboard/analog front end.
 */
// Added by the designer: the register addresses and the Wishbone slave port.
`default_nettype none
module pcc_panel_end import pcc_pkg::*; #(
	parameter int unsigned MS_CYC = MS_CYCLES
) (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	pcc_can_if.panel can,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [WB_AW-1:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic [SW_N-1:0] i_sw_on,
	input wire logic [15:0] i_sw_val [SW_N],
	input wire logic [15:0] i_grp_val [GRP_N],
	input wire logic [9:0] i_analog [ANALOG_N],
	output logic [SW_N-1:0] o_red_led,
	output logic [7:0] o_led_bright,
	output logic [7:0] o_backlight,
	output logic o_term_en,
	output logic [9:0] o_bitrate_kbps
);
	typedef enum logic [1:0] {S_IDLE, S_LOAD, S_SEND} pcc_state_t;
	localparam int unsigned TW = $clog2(MS_CYC + 1);
	localparam logic [3:0] JOB_LAST = 4'(JOB_N - 1);
	localparam logic [3:0] JOB_ADV_PRI = 4'(XID_N);
	localparam logic [3:0] JOB_ADV_SEC = 4'(XID_N + 1);
	localparam logic [3:0] JOB_LEG_PRI = 4'(XID_N + 2);

	// ==========================================
	// registers
	logic [7:0] ctrl_q;
	logic [9:0] kbps_q;
	logic [15:0] period_q;
	logic [29:0] rxid_q, adv_pri_q, adv_sec_q, leg_pri_q, leg_sec_q;
	logic [31:0] bright_q;
	logic [8:0] altsw_q;
	logic [30:0] xid_q [XID_N];
	logic [11:0] slot_q [XID_N*SLOT_N];
	logic [SW_N-1:0] red_q, sw_prev_q;
	logic ack_q;
	logic [31:0] rdat_q;

	// ==========================================
	// wishbone decode
	wire wb_go = i_wb_cyc && i_wb_stb && !ack_q;
	wire wb_wr = wb_go && i_wb_we;
	wire [31:0] wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
	wire xid_hit = (i_wb_adr[8:5] == XID_PAGE);
	wire slot_hit = (i_wb_adr[8] == SLOT_PAGE);
	wire [2:0] xid_idx = i_wb_adr[4:2];
	wire [5:0] slot_idx = i_wb_adr[7:2];

	function automatic logic [31:0] merge(input logic [31:0] old);
		merge = (old & ~wmask) | (i_wb_dat & wmask);
	endfunction

	logic [31:0] rd_d;
	always_comb begin
		case (i_wb_adr)
			ADR_CTRL: rd_d = {24'h000000, ctrl_q};
			ADR_KBPS: rd_d = {22'h000000, kbps_q};
			ADR_PERIOD: rd_d = {16'h0000, period_q};
			ADR_RXID: rd_d = {2'h0, rxid_q};
			ADR_ADV_PRI: rd_d = {2'h0, adv_pri_q};
			ADR_ADV_SEC: rd_d = {2'h0, adv_sec_q};
			ADR_LEG_PRI: rd_d = {2'h0, leg_pri_q};
			ADR_LEG_SEC: rd_d = {2'h0, leg_sec_q};
			ADR_BRIGHT: rd_d = bright_q;
			ADR_ALTSW: rd_d = {23'h000000, altsw_q};
			ADR_STATUS: rd_d = {12'h000, red_q};
			default: begin
				if (slot_hit) begin
					rd_d = {20'h00000, slot_q[slot_idx]};
				end else if (xid_hit) begin
					rd_d = {1'h0, xid_q[xid_idx]};
				end else begin
					rd_d = '0; // unmapped reads zero
				end
			end
		endcase
	end

	// ==========================================
	// legacy receive
	function automatic logic [28:0] id_of(input logic [29:0] r);
		// standard idents are cut to 11 bits so they never pass 7FF
		id_of = r[ID_EXT_BIT] ? r[28:0] : {18'h00000, r[10:0] & STD_ID_MAX};
	endfunction

	wire rx_hit = can.m2p_valid && (can.m2p_ext == rxid_q[ID_EXT_BIT])
		&& (can.m2p_id == id_of(rxid_q));
	wire [7:0] rx_tag = can.m2p_data[BYTE_TAG*8 +: 8];
	wire rx_fault = rx_hit && (rx_tag == FAULT_TAG);
	wire rx_bright = rx_hit && (rx_tag == BRIGHT_TAG);

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl_q <= '0;
			kbps_q <= KBPS_RESET;
			period_q <= PERIOD_RESET;
			rxid_q <= '0;
			adv_pri_q <= '0;
			adv_sec_q <= '0;
			leg_pri_q <= '0;
			leg_sec_q <= '0;
			bright_q <= BRIGHT_RESET;
			altsw_q <= '0;
			red_q <= '0;
			ack_q <= 1'h0;
			rdat_q <= '0;
			for (int i = 0; i < XID_N; i++) xid_q[i] <= '0;
			for (int i = 0; i < XID_N*SLOT_N; i++) slot_q[i] <= '0;
		end else begin
			ack_q <= wb_go;
			if (wb_go) rdat_q <= rd_d;
			if (wb_wr) begin
				case (i_wb_adr)
					ADR_CTRL: ctrl_q <= 8'(merge({24'h000000, ctrl_q}));
					ADR_KBPS: kbps_q <= 10'(merge({22'h000000, kbps_q}));
					ADR_PERIOD: period_q <= 16'(merge({16'h0000, period_q}));
					ADR_RXID: rxid_q <= 30'(merge({2'h0, rxid_q}));
					ADR_ADV_PRI: adv_pri_q <= 30'(merge({2'h0, adv_pri_q}));
					ADR_ADV_SEC: adv_sec_q <= 30'(merge({2'h0, adv_sec_q}));
					ADR_LEG_PRI: leg_pri_q <= 30'(merge({2'h0, leg_pri_q}));
					ADR_LEG_SEC: leg_sec_q <= 30'(merge({2'h0, leg_sec_q}));
					ADR_BRIGHT: bright_q <= merge(bright_q);
					ADR_ALTSW: altsw_q <= 9'(merge({23'h000000, altsw_q}));
					default: begin
						if (slot_hit) begin
							slot_q[slot_idx] <= 12'(merge({20'h00000, slot_q[slot_idx]}));
						end else if (xid_hit) begin
							xid_q[xid_idx] <= 31'(merge({1'h0, xid_q[xid_idx]}));
						end
					end
				endcase
			end
			// a received command wins over a bus write in the same cycle
			if (rx_bright) begin
				bright_q[15:0] <= {can.m2p_data[BYTE_BACK*8 +: 8],
					can.m2p_data[BYTE_LED*8 +: 8]};
			end
			if (rx_fault) begin
				red_q <= {can.m2p_data[43:40], can.m2p_data[55:48],
					can.m2p_data[63:56]};
			end
		end
	end

	assign o_wb_ack = ack_q;
	assign o_wb_dat = rdat_q;
	assign can.m2p_ready = 1'h1;
	assign o_red_led = red_q;
	assign o_term_en = ctrl_q[CTRL_TERM];
	assign o_bitrate_kbps = (kbps_q < KBPS_MIN) ? KBPS_MIN
		: ((kbps_q > KBPS_MAX) ? KBPS_MAX : kbps_q);

	// ==========================================
	// brightness
	wire alt_on = altsw_q[ALT_EN_BIT] && (altsw_q[4:0] < 5'(SW_N))
		&& i_sw_on[altsw_q[4:0]];
	wire [7:0] led_lvl = alt_on ? bright_q[23:16] : bright_q[7:0];
	wire [7:0] back_lvl = alt_on ? bright_q[31:24] : bright_q[15:8];
	// v1: level 0 keeps indicators at minimum but darkens the backlight
	wire [7:0] led_v1 = {led_lvl[2:0], V1_FILL};
	wire [7:0] back_v1 = (back_lvl[2:0] == 3'h0) ? 8'h00 : {back_lvl[2:0], V1_FILL};

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_led_bright <= '0;
			o_backlight <= '0;
		end else begin
			o_led_bright <= ctrl_q[CTRL_HW_V1] ? led_v1 : led_lvl;
			o_backlight <= ctrl_q[CTRL_HW_V1] ? back_v1 : back_lvl;
		end
	end

	// ==========================================
	// transmit triggers
	pcc_state_t st_q;
	logic [3:0] job_q;
	logic [TW-1:0] tick_q;
	logic [15:0] ms_q;
	logic pend_q;
	logic [28:0] fid_q;
	logic fext_q;
	logic [63:0] fdata_q;

	wire tick = (tick_q == TW'(MS_CYC - 1));
	wire period_done = tick && ({1'h0, ms_q} + 17'h00001 >= {1'h0, period_q});
	wire sw_changed = (i_sw_on != sw_prev_q);
	wire trig = (ctrl_q[CTRL_ON_CHANGE] && sw_changed)
		|| (ctrl_q[CTRL_PERIODIC] && period_done);
	wire start = (st_q == S_IDLE) && pend_q;

	// ==========================================
	// frame build
	function automatic logic [7:0] slot_byte(input logic [11:0] ent);
		logic [15:0] sv;
		logic [15:0] gv;
		logic [9:0] av;
		sv = (ent[4:0] < 5'(SW_N)) ? i_sw_val[ent[4:0]] : 16'h0000;
		gv = (ent[4:0] < 5'(GRP_N)) ? i_grp_val[ent[4:0]] : 16'h0000;
		av = i_analog[ent[1:0]];
		case (ent[11:8])
			KIND_SW_LO: slot_byte = sv[7:0];
			KIND_SW_HI: slot_byte = sv[15:8];
			KIND_GRP_LO: slot_byte = gv[7:0];
			KIND_GRP_HI: slot_byte = gv[15:8];
			KIND_CONST: slot_byte = ent[7:0];
			KIND_AN8: slot_byte = av[9:2];
			KIND_AN_LO: slot_byte = av[7:0];
			KIND_AN_HI: slot_byte = {6'h00, av[9:8]};
			default: slot_byte = 8'h00;
		endcase
	endfunction

	logic [63:0] exp_data;
	always_comb begin
		exp_data = '0;
		for (int s = 0; s < SLOT_N; s++) begin
			exp_data[s*8 +: 8] = slot_byte(slot_q[{job_q[2:0], 3'(s)}]);
		end
	end

	wire [63:0] sw_data = {i_sw_on[7:0], i_sw_on[15:8], 4'h0, i_sw_on[19:16], 40'h00_0000_0000};
	logic [29:0] job_id;
	logic job_on;
	always_comb begin
		job_id = '0;
		job_on = 1'h0;
		if (job_q < JOB_ADV_PRI) begin
			job_id = xid_q[job_q[2:0]][29:0];
			job_on = ctrl_q[CTRL_EXPORT] && xid_q[job_q[2:0]][ID_EN_BIT];
		end else begin
			case (job_q)
				JOB_ADV_PRI: begin
					job_id = adv_pri_q;
					job_on = 1'h1;
				end
				JOB_ADV_SEC: begin
					job_id = adv_sec_q;
					job_on = ctrl_q[CTRL_ADV_SEC];
				end
				JOB_LEG_PRI: begin
					job_id = leg_pri_q;
					job_on = ctrl_q[CTRL_LEGACY];
				end
				default: begin
					job_id = leg_sec_q;
					job_on = ctrl_q[CTRL_LEGACY];
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_q <= S_IDLE;
			job_q <= '0;
			tick_q <= '0;
			ms_q <= '0;
			pend_q <= 1'h0;
			sw_prev_q <= '0;
			fid_q <= '0;
			fext_q <= 1'h0;
			fdata_q <= '0;
		end else begin
			tick_q <= tick ? '0 : tick_q + TW'(1);
			ms_q <= period_done ? '0 : (tick ? ms_q + 16'h0001 : ms_q);
			sw_prev_q <= i_sw_on;
			pend_q <= trig || (pend_q && !start); // a new trigger wins over the consume
			case (st_q)
				S_IDLE: begin
					if (start) begin
						job_q <= '0;
						st_q <= S_LOAD;
					end
				end
				S_LOAD: begin
					if (job_on) begin
						fid_q <= id_of(job_id);
						fext_q <= job_id[ID_EXT_BIT];
						fdata_q <= (job_q < JOB_ADV_PRI) ? exp_data : sw_data;
						st_q <= S_SEND;
					end else if (job_q == JOB_LAST) begin
						st_q <= S_IDLE;
					end else begin
						job_q <= job_q + 4'h1;
					end
				end
				S_SEND: begin
					if (can.p2m_ready) begin
						st_q <= (job_q == JOB_LAST) ? S_IDLE : S_LOAD;
						job_q <= (job_q == JOB_LAST) ? job_q : job_q + 4'h1;
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	assign can.p2m_valid = (st_q == S_SEND);
	assign can.p2m_id = fid_q;
	assign can.p2m_ext = fext_q;
	assign can.p2m_data = fdata_q;
endmodule
`default_nettype wire

//--- tb/pcc_link_props.sv
/*
 checker of the frame link between panel end and power end.
 assumes one clock domain, async active-low reset, interval of one ms tick.
*/
`default_nettype none
module pcc_link_props (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic p2m_valid,
	input wire logic p2m_ready,
	input wire logic [28:0] p2m_id,
	input wire logic p2m_ext,
	input wire logic m2p_valid,
	input wire logic m2p_ready,
	input wire logic [28:0] m2p_id,
	input wire logic m2p_ext,
	input wire logic [63:0] m2p_data
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);
	// ==========================================
	// frame steps
	sequence s_fault;
		m2p_valid && m2p_data[7:0] == 8'h0A;
	endsequence
	sequence s_p2m_take;
		p2m_valid && p2m_ready;
	endsequence
	// ==========================================
	// link rules
	chk_std_panel:
		assert property (p2m_valid && !p2m_ext |-> p2m_id[28:11] == 18'h0)
		else $error("panel standard id too wide");
	chk_std_power:
		assert property (m2p_valid && !m2p_ext |-> m2p_id[28:11] == 18'h0)
		else $error("power standard id too wide");
	chk_panel_gap:
		assert property (s_p2m_take |=> !p2m_valid)
		else $error("panel frames without load gap");
	chk_power_tag:
		assert property (m2p_valid |-> m2p_data[7:0] inside {8'h0A, 8'h34})
		else $error("power frame with unknown tag");
	chk_fault_layout:
		assert property (s_fault |-> m2p_data[47:44] == 4'h0)
		else $error("fault frame upper nibble of byte 5 set");
	chk_no_stall:
		assert property (p2m_ready && m2p_ready)
		else $error("receiver stalled");
	chk_quiet_start:
		assert property ($rose(i_resetn) |-> !p2m_valid && !m2p_valid)
		else $error("frame offered at reset release");
	chk_fault_repeat:
		assert property (s_fault |-> ##[1:100] s_fault)
		else $error("fault frame not repeated");
endmodule
`default_nettype wire

//--- tb/pcc_panel_can_message_codec_tb.sv
/*
 self-checking bench: panel end and power end joined by pcc_can_if.
 assumes a short ms tick (20 cycles) so periodic frames come quickly.
*/
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
`define WAITF(c) for (k = 0; k < 300 && !(c); k++) @(posedge clk);
module pcc_panel_can_message_codec_tb import pcc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, ack, term, busy, breq = 0, sword = 1;
	logic [8:0] adr = 9'h000;
	logic [3:0] sel = 4'hF;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic [19:0] sw_on = 20'h0, red, evt, psw;
	logic [15:0] sw_val [SW_N], grp_val [GRP_N], dv;
	logic [9:0] an [ANALOG_N], kbps;
	logic [7:0] lvl [SW_N], led, back, bled = 8'h00, bback = 8'h00;
	logic [29:0] fid = 30'h123;
	logic [19:0] pat [4] = '{20'h00001, 20'h80000, 20'h00000, 20'hA5A5A};
	logic [7:0] hi [4] = '{8'h02, 8'hFF, 8'h02, 8'hFF};
	logic [7:0] lo [4] = '{8'h00, 8'h01, 8'h01, 8'h00};
	logic [9:0] kin [4] = '{10'h005, 10'h00A, 10'h3E8, 10'h3FF};
	logic [9:0] kex [4] = '{10'h00A, 10'h00A, 10'h3E8, 10'h3E8};
	int n_mismatch = 0, n_checks = 0, k;
	always #5 clk = ~clk;
	pcc_can_if can();
	pcc_panel_end #(.MS_CYC(20)) i_pcc_panel_end (.i_ref_clk(clk), .i_resetn(rstn), .can(can),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
		.i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_sw_on(sw_on), .i_sw_val(sw_val),
		.i_grp_val(grp_val), .i_analog(an), .o_red_led(red), .o_led_bright(led),
		.o_backlight(back), .o_term_en(term), .o_bitrate_kbps(kbps));
	pcc_power_end #(.MS_CYC(20)) i_pcc_power_end (.i_ref_clk(clk), .i_resetn(rstn), .can(can),
		.i_fault_level(lvl), .i_fault_ident(fid), .i_interval_ms(16'h0001),
		.i_bright_req(breq), .i_bright_led(bled), .i_bright_back(bback),
		.i_panel_ident(30'h055), .i_supply_ident(30'h300), .i_supply_slot(3'h0),
		.i_supply_word(sword), .o_fault_evt(evt), .o_panel_sw(psw), .o_supply_dv(dv),
		.o_bright_busy(busy));
	pcc_link_props i_pcc_link_props (.i_ref_clk(clk), .i_resetn(rstn),
		.p2m_valid(can.p2m_valid), .p2m_ready(can.p2m_ready), .p2m_id(can.p2m_id),
		.p2m_ext(can.p2m_ext), .m2p_valid(can.m2p_valid), .m2p_ready(can.m2p_ready),
		.m2p_id(can.m2p_id), .m2p_ext(can.m2p_ext), .m2p_data(can.m2p_data));
	// ==========================================
	// bus and report tasks
	// ack is read before the edge's updates land, i.e. as sampled by that edge
	task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
		k = 0;
		do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 50);
		if (k == 50) n_mismatch++;
		q = rdat;
		cyc <= 0; stb <= 0;
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ==========================================
	// sequence
	initial begin
		foreach (lvl[i]) begin lvl[i] = 8'h00; sw_val[i] = 16'h0000; grp_val[i] = 16'h0000; end
		foreach (an[i]) an[i] = 10'h1A4;
		repeat (3) @(posedge clk);
		`CHK(kbps, 10'h1F4)
		`CHK(red, 20'h0)
		`CHK(term, 1'b0)
		rstn <= 1;
		$display("test reset done");
		wb(1, ADR_RXID, 32'h123);
		for (int r = 0; r < 4; r++) begin
			@(posedge clk);
			foreach (lvl[i]) lvl[i] <= pat[r][i] ? hi[r] : lo[r];
			`WAITF(red === pat[r])
			`CHK(red, pat[r])
			`CHK(evt, pat[r])
			wb(0, ADR_STATUS, 32'h0);
			`CHK(q[19:0], pat[r])
		end
		$display("test fault rows done");
		for (int r = 0; r < 4; r++) begin
			wb(1, ADR_KBPS, {22'h0, kin[r]});
			@(posedge clk);
			`CHK(kbps, kex[r])
		end
		// brightness frames must leave the red states alone
		for (int r = 0; r < 2; r++) begin
			@(posedge clk);
			bled <= r ? 8'h00 : 8'h5A; bback <= r ? 8'hFF : 8'hC3; breq <= 1;
			@(posedge clk);
			breq <= 0;
			@(posedge clk);
			`CHK(busy, 1'h1)
			`WAITF(led === bled && back === bback)
			`CHK({led, back}, {bled, bback})
			`CHK(red, 20'hA5A5A)
		end
		$display("test brightness done");
		wb(1, ADR_CTRL, 32'h0000_0001);
		@(posedge clk);
		`CHK(term, 1'b1)
		wb(1, ADR_LEG_PRI, 32'h055);
		wb(1, ADR_CTRL, 32'h0000_0006);
		@(posedge clk);
		`CHK(term, 1'b0)
		sw_on <= 20'h80301;
		`WAITF(psw === 20'h80301)
		`CHK(psw, 20'h80301)
		wb(1, ADR_LEG_PRI, 32'h7FF);
		wb(1, ADR_ADV_PRI, 32'h055);
		wb(1, ADR_CTRL, 32'h0000_0004);
		sw_on <= 20'h00010;
		`WAITF(psw === 20'h00010)
		`CHK(psw, 20'h00010)
		wb(1, ADR_PERIOD, 32'h1);
		wb(1, ADR_CTRL, 32'h0000_0008);
		sw_on <= 20'h0F0F0;
		`WAITF(psw === 20'h0F0F0)
		`CHK(psw, 20'h0F0F0)
		$display("test switch frames done");
		// byte lanes: only the normal levels are written, alternative ones stay
		sel <= 4'h3;
		wb(1, ADR_BRIGHT, 32'h1234_0600);
		sel <= 4'hF;
		wb(1, ADR_CTRL, 32'h0000_0040);
		repeat (2) @(posedge clk);
		`CHK({led, back}, 16'h1FDF)
		wb(1, ADR_ALTSW, 32'h0000_0104);
		repeat (2) @(posedge clk);
		`CHK({led, back}, 16'h1F00)
		sw_on <= 20'h00000;
		repeat (2) @(posedge clk);
		`CHK({led, back}, 16'h1FDF)
		$display("test dimming done");
		wb(1, 9'h040, 32'h4000_0300);
		wb(1, 9'h100, 32'h0000_0703);
		wb(1, 9'h104, 32'h0000_0803);
		wb(1, ADR_CTRL, 32'h0000_0018);
		`WAITF(dv === 16'd120)
		`CHK(dv, 16'd120)
		wb(1, 9'h100, 32'h0000_0603);
		sword <= 0;
		an[3] <= 10'h3FF;
		`WAITF(dv === 16'd292)
		`CHK(dv, 16'd292)
		sw_val[2] <= 16'h12A7;
		grp_val[5] <= 16'h3C00;
		wb(1, ADR_ADV_PRI, 32'h7FE);
		wb(1, 9'h040, 32'h4000_0055);
		wb(1, 9'h11C, 32'h0000_0102);
		wb(1, 9'h118, 32'h0000_0405);
		wb(1, 9'h114, 32'h0000_050C);
		`WAITF(psw === 20'hC3CA7)
		`CHK(psw, 20'hC3CA7)
		wb(0, 9'h0FC, 32'h0);
		`CHK(q, 32'h0)
		$display("test export done");
		rstn <= 0;
		@(posedge clk);
		`CHK({red, term, kbps}, {20'h00000, 1'h0, 10'h1F4})
		rstn <= 1;
		repeat (2) @(posedge clk);
		`CHK({led, back}, 16'hFFFF)
		$display("test mid reset done");
		report_and_stop();
	end
	initial begin
		#200000;
		n_mismatch++;
		report_and_stop();
	end
endmodule
`default_nettype wire
